// [edge_watch.v]
// Edge detector for a synchronous input, comparing it with its registered previous value
`timescale 1ns/100ps
`default_nettype none

module edge_watch (
    input  wire clk_sys,
    input  wire rst_b,
    input  wire sig,
    output wire rise,
    output wire fall
);

    reg last_q;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            last_q <= 1'b0;
        end else begin
            last_q <= sig;
        end
    end

    assign rise = sig & ~last_q;
    assign fall = ~sig & last_q;

endmodule
`default_nettype wire

// [gated_pulse_train_counter.v]
// Gated pulse train generator and gate width/period meter
// What this block does
// RL1 - Pulse count zero runs forever; otherwise emit exactly the requested count. Here a count of all ones also runs forever, in every gate mode.
// RL2 - One cycle lasts delay plus width timebase ticks, setting repetition rate.
// RL3 - Pulse phase length is software width, giving duty cycle; default half.
// RL4 - Zero or full duty is clamped so a cycle spans at least three ticks.
// RL5 - Internal timebase unless external selected; external tick from timebase input.
// RL6 - Gate mode zero ignores gate, starts on software start.
// RL7 - Mode one counts while gate high, mode two while gate low.
// RL8 - Mode three starts on gate rising edge, mode four on falling.
// RL9 - Count zero with edge mode: one pulse per edge, retriggerable.
// RL10 - Count all ones with edge mode: continuous train from the edge.
// RL11 - Polarity zero: delay low, pulse high; polarity one inverted.
// RL12 - Achieved delay and width after clamping are readable by software.
// RL13 - Measurement counts internal ticks while the gate enables counting.
// RL14 - Measure high width, low width, rise-to-rise or fall-to-fall period.
// RL15 - Each cycle is a delay phase then a pulse phase, repeating.
// RL16 - After a finite count, hold delay level and stop until restarted.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "pulse_counter_defines.vh"

module gated_pulse_train_counter #(
    parameter integer CW = 16
) (
    input  wire          clk_sys,
    input  wire          rst_b,
    input  wire [3:0]    reg_addr,
    input  wire [31:0]   reg_wdata,
    input  wire          reg_wr,
    input  wire          reg_rd,
    output reg  [31:0]   reg_rdata,
    input  wire          counter_gate_input,
    input  wire          ext_timebase,
    output reg           counter_pulse_output
);

    // ============================================================
    // Configuration registers
    reg          pol_q;
    reg          ext_q;
    reg  [2:0]   gate_mode_q;
    reg          meas_q;
    reg  [1:0]   mtype_q;
    reg  [CW-1:0] delay_q;
    reg  [CW-1:0] width_q;
    reg  [31:0]  count_q;

    // ============================================================
    // Generator state
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ARMED = 2'd1;
    localparam [1:0] ST_DELAY = 2'd2;
    localparam [1:0] ST_PULSE = 2'd3;

    reg  [1:0]   state_q;
    reg  [1:0]   state_d;
    reg  [CW-1:0] phase_q;
    reg  [31:0]  done_q;
    reg          one_shot_q;
    reg          finished_q;

    // Measurement state
    reg  [CW-1:0] meas_cnt_q;
    reg  [CW-1:0] meas_res_q;
    reg          meas_run_q;
    reg          meas_valid_q;
    reg          meas_ovf_q;

    wire int_tick;
    wire gate_rise;
    wire gate_fall;
    wire ext_rise;

    tick_divider #(
        .DIV (`INT_TB_DIV)
    ) u_div (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .tick    (int_tick)
    );

    edge_watch u_gate_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .sig     (counter_gate_input),
        .rise    (gate_rise),
        .fall    (gate_fall)
    );

    edge_watch u_tb_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .sig     (ext_timebase),
        .rise    (ext_rise),
        .fall    ()
    );

    // ============================================================
    // Timebase and gate qualification
    wire tb_tick = ext_q ? ext_rise : int_tick; // [RL5]

    reg gate_ok;
    always @* begin
        case (gate_mode_q)
            3'd1:    gate_ok = counter_gate_input; // [RL7]
            3'd2:    gate_ok = ~counter_gate_input; // [RL7]
            default: gate_ok = 1'b1; // [RL6]
        endcase
    end

    wire edge_mode = (gate_mode_q == 3'd3) || (gate_mode_q == 3'd4);
    wire trig = (gate_mode_q == 3'd3) ? gate_rise : // [RL8]
                (gate_mode_q == 3'd4) ? gate_fall : 1'b0;

    // Clamp a zero delay or width so delay + width is at least three ticks
    wire [CW-1:0] act_delay = (delay_q == {CW{1'b0}}) ? // [RL4]
        ((width_q >= 2) ? {{(CW-1){1'b0}}, 1'b1} : {{(CW-2){1'b0}}, 2'b10}) : delay_q;
    wire [CW-1:0] act_width = (width_q == {CW{1'b0}}) ? // [RL4]
        ((delay_q >= 2) ? {{(CW-1){1'b0}}, 1'b1} : {{(CW-2){1'b0}}, 2'b10}) : width_q;

    wire wr_ctrl = reg_wr && (reg_addr == `OFS_CTRL);
    wire start   = wr_ctrl && reg_wdata[`CTRL_START_BIT];
    wire stop    = wr_ctrl && reg_wdata[`CTRL_STOP_BIT];
    wire step    = tb_tick && gate_ok;

    // Infinite when count is zero (except edge one-shot) or all ones
    wire infinite = ((count_q == 32'h0000_0000) && !edge_mode) || // [RL1]
                    (count_q == 32'hFFFF_FFFF); // [RL10]
    wire last_pulse = one_shot_q ||
                      (!infinite && (done_q + 32'h0000_0001 >= count_q)); // [RL16]

    // ============================================================
    // Register writes
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            pol_q       <= 1'b0;
            ext_q       <= 1'b0;
            gate_mode_q <= `RST_GATE_MODE;
            meas_q      <= 1'b0;
            mtype_q     <= `RST_MTYPE;
            delay_q     <= `RST_DELAY;
            width_q     <= `RST_WIDTH; // [RL3]
            count_q     <= 32'h0000_0000; // [RL1]
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_CTRL: begin
                    pol_q       <= reg_wdata[`CTRL_POL_BIT];
                    ext_q       <= reg_wdata[`CTRL_EXT_BIT];
                    gate_mode_q <= reg_wdata[`CTRL_GATE_HI:`CTRL_GATE_LO];
                    meas_q      <= reg_wdata[`CTRL_MEAS_BIT];
                    mtype_q     <= reg_wdata[`CTRL_MTYPE_HI:`CTRL_MTYPE_LO];
                end
                `OFS_DELAY: delay_q <= reg_wdata[CW-1:0];
                `OFS_WIDTH: width_q <= reg_wdata[CW-1:0];
                `OFS_COUNT: count_q <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ============================================================
    // Pulse train sequencer
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // The measure bit of this same write decides, not the stored one
                if (start && !reg_wdata[`CTRL_MEAS_BIT]) begin
                    state_d = (reg_wdata[`CTRL_GATE_HI:`CTRL_GATE_LO] == 3'd3 ||
                               reg_wdata[`CTRL_GATE_HI:`CTRL_GATE_LO] == 3'd4) ?
                              ST_ARMED : ST_DELAY;
                end
            end
            ST_ARMED: begin
                if (trig) begin
                    state_d = ST_DELAY; // [RL8]
                end
            end
            ST_DELAY: begin
                if (step && phase_q + 1'b1 >= act_delay) begin
                    state_d = ST_PULSE; // [RL15]
                end
            end
            ST_PULSE: begin
                if (step && phase_q + 1'b1 >= act_width) begin
                    state_d = last_pulse ? (one_shot_q ? ST_ARMED : ST_IDLE)
                                         : ST_DELAY; // [RL2] [RL15]
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Retrigger restarts the delay phase from any running state
        if (one_shot_q && trig && state_q != ST_IDLE) begin
            state_d = ST_DELAY; // [RL9]
        end
        if (stop) begin
            state_d = ST_IDLE;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q    <= ST_IDLE;
            phase_q    <= {CW{1'b0}};
            done_q     <= 32'h0000_0000;
            one_shot_q <= 1'b0;
            finished_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q || (one_shot_q && trig)) begin
                phase_q <= {CW{1'b0}};
            end else if (step && (state_q == ST_DELAY || state_q == ST_PULSE)) begin
                phase_q <= phase_q + 1'b1;
            end
            if (start) begin
                done_q     <= 32'h0000_0000;
                finished_q <= 1'b0;
                one_shot_q <= (count_q == 32'h0000_0000) &&
                              (reg_wdata[`CTRL_GATE_HI:`CTRL_GATE_LO] == 3'd3 ||
                               reg_wdata[`CTRL_GATE_HI:`CTRL_GATE_LO] == 3'd4); // [RL9]
            end else if (state_q == ST_PULSE && state_d != ST_PULSE) begin
                done_q <= done_q + 32'h0000_0001;
                if (state_d == ST_IDLE) begin
                    finished_q <= 1'b1; // [RL16]
                end
            end
        end
    end

    // Output flop: idle and delay show the delay level
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            counter_pulse_output <= 1'b0;
        end else begin
            counter_pulse_output <= (state_d == ST_PULSE) ^ pol_q; // [RL11]
        end
    end

    // ============================================================
    // Width and period measurement
    reg meas_en;
    reg meas_end;
    always @* begin
        case (mtype_q)
            2'd0:    begin meas_en = gate_rise; meas_end = gate_fall; end
            2'd1:    begin meas_en = gate_fall; meas_end = gate_rise; end
            2'd3:    begin meas_en = gate_fall; meas_end = gate_fall; end
            default: begin meas_en = gate_rise; meas_end = gate_rise; end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            meas_cnt_q   <= {CW{1'b0}};
            meas_res_q   <= {CW{1'b0}};
            meas_run_q   <= 1'b0;
            meas_valid_q <= 1'b0;
            meas_ovf_q   <= 1'b0;
        end else if (!meas_q || start) begin
            meas_run_q <= 1'b0;
            if (start) begin
                meas_valid_q <= 1'b0;
                meas_ovf_q   <= 1'b0;
            end
        end else if (meas_run_q && meas_end) begin
            // A tick on the closing edge counts too, so the window is exact
            if (int_tick && meas_cnt_q != {CW{1'b1}}) begin
                meas_res_q <= meas_cnt_q + 1'b1; // [RL14]
            end else begin
                meas_res_q <= meas_cnt_q; // [RL14]
            end
            meas_valid_q <= 1'b1;
            meas_run_q   <= 1'b0;
        end else if (!meas_run_q && !meas_valid_q && meas_en) begin
            meas_run_q <= 1'b1;
            meas_cnt_q <= {CW{1'b0}};
        end else if (meas_run_q && int_tick) begin
            // Internal timebase only, so time equals count over 10 MHz
            if (meas_cnt_q == {CW{1'b1}}) begin
                meas_ovf_q <= 1'b1;
            end else begin
                meas_cnt_q <= meas_cnt_q + 1'b1; // [RL13]
            end
        end
    end

    // ============================================================
    // Read port, data valid the cycle after the strobe
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_CTRL:      reg_rdata <= {22'h00_0000, mtype_q, meas_q,
                                              gate_mode_q, ext_q, pol_q, 2'b00};
                `OFS_DELAY:     reg_rdata <= {{(32-CW){1'b0}}, delay_q};
                `OFS_WIDTH:     reg_rdata <= {{(32-CW){1'b0}}, width_q};
                `OFS_COUNT:     reg_rdata <= count_q;
                `OFS_STATUS:    reg_rdata <= {25'h000_0000, meas_ovf_q, meas_valid_q,
                                              meas_run_q, finished_q, state_q, 1'b0};
                `OFS_ACT_DELAY: reg_rdata <= {{(32-CW){1'b0}}, act_delay}; // [RL12]
                `OFS_ACT_WIDTH: reg_rdata <= {{(32-CW){1'b0}}, act_width}; // [RL12]
                `OFS_MEAS:      reg_rdata <= {{(32-CW){1'b0}}, meas_res_q};
                `OFS_DONE_CNT:  reg_rdata <= done_q;
                default:        reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// [gated_pulse_train_counter_asserts.sv]
// Port-level assertions for the gated pulse train counter
`timescale 1ns/100ps
`default_nettype none
module gated_pulse_train_counter_asserts (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        counter_gate_input,
    input wire logic        ext_timebase,
    input wire logic        counter_pulse_output
);
    logic [2:0] mode_q;
    logic       pol_q;
    wire        ctl_wr = reg_wr && reg_addr == 4'h0;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    // ============================================================
    // Control mirror, so gating and stop levels can be judged
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_q <= 3'h0;
            pol_q  <= 1'b0;
        end else if (ctl_wr) begin
            mode_q <= reg_wdata[6:4];
            pol_q  <= reg_wdata[2];
        end
    end
    chk_rd_idle: assert property (!$past(reg_rd) |-> ~|reg_rdata)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 4'h8 |=> ~|reg_rdata)
        else $error("unmapped read not zero");
    chk_ctrl_rsvd: assert property (reg_rd && reg_addr == 4'h0 |=>
        reg_rdata[1:0] == 2'b00 && ~|reg_rdata[31:10])
        else $error("control readback reserved bits set");
    chk_reset_level: assert property ($rose(rst_b) |-> !counter_pulse_output)
        else $error("output not low after reset");
    chk_stop_level: assert property (ctl_wr && reg_wdata[1] |=>
        ##[0:1] counter_pulse_output == pol_q)
        else $error("stop did not return output to delay level");
    // Edge modes may retrigger mid-phase, so only level modes are held to this
    chk_min_phase: assert property ($changed(counter_pulse_output) && mode_q < 3'h3 |=>
        ($stable(counter_pulse_output) || $past(ctl_wr)) [*3])
        else $error("output phase shorter than one tick");
    chk_gate_high: assert property ((mode_q == 3'h1 && !counter_gate_input && !ctl_wr) [*6]
        |=> $stable(counter_pulse_output))
        else $error("output moved while gate low in mode one");
    chk_gate_low: assert property ((mode_q == 3'h2 && counter_gate_input && !ctl_wr) [*6]
        |=> $stable(counter_pulse_output))
        else $error("output moved while gate high in mode two");
endmodule
bind gated_pulse_train_counter gated_pulse_train_counter_asserts u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .counter_gate_input(counter_gate_input), .ext_timebase(ext_timebase),
    .counter_pulse_output(counter_pulse_output));
`default_nettype wire

// [gated_pulse_train_counter_tb.sv]
// Self-checking bench for the gated pulse train counter
`timescale 1ns/100ps
`default_nettype none
module gated_pulse_train_counter_tb;
    logic        clk_sys, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] rd_q[$];
    logic        pol_exp = 1'b0, watch = 1'b0, rd_d = 1'b0;
    wire  [31:0] reg_rdata;
    wire         counter_gate_input, ext_timebase, counter_pulse_output;
    int          len_q[$];
    int          num_errors = 0, tests_run = 0;
    int          run = 0, last_end = 0, per_exp = 0, seen = 0, cyc = 0;
    gated_pulse_train_counter DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .counter_gate_input(counter_gate_input), .ext_timebase(ext_timebase),
        .counter_pulse_output(counter_pulse_output));
    pulse_io_model io (
        .clk_sys(clk_sys), .counter_pulse_output(counter_pulse_output),
        .counter_gate_input(counter_gate_input), .ext_timebase(ext_timebase));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic chk_len(input string what, input int e, input int g);
        tests_run++;
        if (g != e) begin
            num_errors++;
            $display("[ERR] %s exp %0d got %0d", what, e, g);
        end
    endtask
    // ============================================================
    // Monitor: read slots and pulse-phase lengths in clocks
    always @(posedge clk_sys) begin
        cyc++;
        if (rd_d) chk("reg_rdata", rd_q.pop_front(), reg_rdata);
        rd_d <= reg_rd;
        if (!watch) begin
            run = 0;
            last_end = 0;
        end else if (counter_pulse_output !== pol_exp) begin
            run++;
        end else if (run > 0) begin
            chk_len("width", len_q.pop_front(), run);
            if (last_end > 0 && per_exp > 0) chk_len("period", per_exp, cyc - last_end);
            last_end = cyc;
            run = 0;
            seen++;
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic start(input int d, w, input logic [31:0] n, input logic [2:0] m,
                         input logic p, e, input int k, prd);
        watch <= 1'b0;
        seen = 0;
        per_exp = prd * (d + w) * (e ? 8 : 4);
        repeat (k) len_q.push_back(w * (e ? 8 : 4));
        wr(4'h1, 32'(d));
        wr(4'h2, 32'(w));
        wr(4'h3, n);
        pol_exp <= p;
        wr(4'h0, {24'h00_0000, 1'b0, m, e, p, 2'b01});
        watch <= 1'b1;
    endtask
    task automatic stop();
        watch <= 1'b0;
        wr(4'h0, {29'h0000_0000, pol_exp, 2'b10});
    endtask
    task automatic wait_seen(input int n);
        for (int i = 0; i < 4000 && seen < n; i++) @(posedge clk_sys);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        int d, w;
        void'($urandom(32'h0d3f_5525));
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        rd(4'h0, 32'h0000_0200);
        rd(4'h1, 32'h0000_0001);
        rd(4'h2, 32'h0000_0001);
        rd(4'h3, 32'h0000_0000);
        rd(4'h4, 32'h0000_0000);
        rd(4'hf, 32'h0000_0000);
        wr(4'h1, 32'h0000_0000);
        rd(4'h5, 32'h0000_0002);
        d = 3 + $urandom % 4;
        w = 1 + $urandom % 4;
        for (int p = 0; p < 2; p++) begin
            start(d, w, 32'h0000_0003, 3'h0, p[0], 1'b0, 3, 1);
            rd(4'h5, 32'(d));
            rd(4'h6, 32'(w));
            wait_seen(3);
            repeat (40) @(posedge clk_sys);
            rd(4'h8, 32'h0000_0003);
            rd(4'h4, 32'h0000_0008);
            chk("level", {31'h0000_0000, p[0]}, {31'h0000_0000, counter_pulse_output});
        end
        start(d, w, 32'h0000_0000, 3'h0, 1'b0, 1'b0, 5, 1);
        wait_seen(5);
        stop();
        rd(4'h8, 32'h0000_0005);
        for (int m = 1; m < 3; m++) begin
            io.gate_to(m == 2, 4);
            start(d, w, 32'h0000_0002, m[2:0], 1'b0, 1'b0, 2, 0);
            repeat (300) @(posedge clk_sys);
            rd(4'h8, 32'h0000_0000);
            io.gate_to(m == 1, 0);
            wait_seen(2);
            rd(4'h8, 32'h0000_0002);
        end
        for (int m = 3; m < 5; m++) begin
            io.gate_to(m == 4, 4);
            start(d, w, 32'h0000_0000, m[2:0], 1'b0, 1'b0, 2, 0);
            repeat (200) @(posedge clk_sys);
            rd(4'h8, 32'h0000_0000);
            repeat (2) begin
                io.gate_to(m == 3, 8);
                io.gate_to(m == 4, (d + w) * 4 + 40);
            end
            rd(4'h8, 32'h0000_0002);
            stop();
        end
        io.gate_to(1'b0, 4);
        start(d, w, 32'hffff_ffff, 3'h3, 1'b0, 1'b0, 3, 1);
        repeat (100) @(posedge clk_sys);
        io.gate_to(1'b1, 0);
        wait_seen(3);
        stop();
        io.tb_half = 4;
        start(d, w, 32'h0000_0002, 3'h0, 1'b0, 1'b1, 2, 1);
        wait_seen(2);
        io.tb_half = 0;
        for (int t = 0; t < 4; t++) begin
            io.gate_to(1'b0, 20);
            wr(4'h0, {22'h00_0000, t[1:0], 8'h81});
            repeat (2) begin
                io.gate_to(1'b1, 160);
                io.gate_to(1'b0, 200);
            end
            rd(4'h7, t == 0 ? 32'h0000_0028 : t == 1 ? 32'h0000_0032 : 32'h0000_005a);
        end
        report_and_stop();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// [pulse_counter_defines.vh]
// Constants for the gated pulse train counter
`ifndef PULSE_COUNTER_DEFINES_VH
`define PULSE_COUNTER_DEFINES_VH

// ============================================================
// Register offsets
`define OFS_CTRL        4'h0
`define OFS_DELAY       4'h1
`define OFS_WIDTH       4'h2
`define OFS_COUNT       4'h3
`define OFS_STATUS      4'h4
`define OFS_ACT_DELAY   4'h5
`define OFS_ACT_WIDTH   4'h6
`define OFS_MEAS        4'h7
`define OFS_DONE_CNT    4'h8

// ============================================================
// Control fields
`define CTRL_START_BIT  0
`define CTRL_STOP_BIT   1
`define CTRL_POL_BIT    2
`define CTRL_EXT_BIT    3
`define CTRL_GATE_LO    4
`define CTRL_GATE_HI    6
`define CTRL_MEAS_BIT   7
`define CTRL_MTYPE_LO   8
`define CTRL_MTYPE_HI   9

// ============================================================
// Reset values and limits
`define RST_GATE_MODE   3'h0
`define RST_MTYPE       2'h2
`define RST_DELAY       16'h0001
`define RST_WIDTH       16'h0001
`define MIN_PERIOD_CYC  3
`define INT_TB_HZ       10000000
`define SYS_HZ          40000000
`define INT_TB_DIV      (`SYS_HZ / `INT_TB_HZ)

`endif

// [pulse_io_model.sv]
// Model of the gate source, external timebase and output load
`timescale 1ns/100ps
`default_nettype none
module pulse_io_model (
    input  wire logic clk_sys,
    input  wire logic counter_pulse_output,
    output var  logic counter_gate_input,
    output var  logic ext_timebase
);
    int tb_half;
    int cnt;
    initial begin
        counter_gate_input = 1'b0;
        tb_half = 0;
    end
    // ============================================================
    // Timebase stands low unless a half period is set
    always @(posedge clk_sys) begin
        if (tb_half == 0) begin
            cnt <= 0;
            ext_timebase <= 1'b0;
        end else if (cnt + 1 >= tb_half) begin
            cnt <= 0;
            ext_timebase <= ~ext_timebase;
        end else begin
            cnt <= cnt + 1;
        end
    end
    // Called just after an edge; the level lasts exactly hold cycles
    task automatic gate_to(input logic lvl, input int hold);
        counter_gate_input <= lvl;
        repeat (hold) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// [tick_divider.v]
// Divider producing the internal timebase enable pulse
`timescale 1ns/100ps
`default_nettype none

module tick_divider #(
    parameter integer DIV = 4
) (
    input  wire clk_sys,
    input  wire rst_b,
    output reg  tick
);

    reg [7:0] cnt_q;

    always @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_q <= 8'h00;
            tick  <= 1'b0;
        end else if (cnt_q == DIV[7:0] - 8'h01) begin
            cnt_q <= 8'h00;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule
`default_nettype wire
